/* core/zero_servo_pkg.sv */
package zero_servo_pkg;

    // ==========================================
    // function codes of programmable contacts
    localparam logic [7:0]  ZERO_SERVO_CMD_CODE = 8'h48;   // 72 decimal
    localparam logic [7:0]  ZERO_SERVO_END_CODE = 8'h21;   // 33 decimal
    localparam int          NUM_CONTACT_INPUTS  = 10;
    localparam int          NUM_CONTACT_OUTPUTS = 3;

    // ==========================================
    // settings, frequencies in 0.1 Hz units
    localparam int          FREQ_W              = 16;
    localparam logic [15:0] ZERO_SPEED_MAX      = 16'h0064;  // 10.0 Hz
    localparam logic [15:0] ZERO_SPEED_DEFAULT  = 16'h0005;  // 0.5 Hz
    localparam logic [6:0]  HOLD_GAIN_MAX       = 7'h64;     // 100
    localparam logic [6:0]  HOLD_GAIN_DEFAULT   = 7'h05;
    localparam logic [13:0] HOLD_WIDTH_DEFAULT  = 14'h000a;  // 10 edges
    localparam int          ENC_DECODE_FACTOR   = 4;

    // ==========================================
    // position datapath
    localparam int          POS_W               = 32;
    localparam int          EFFORT_W            = 16;
    localparam logic [15:0] EFFORT_MAX          = 16'h7fff;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD
    } zs_state_type;

endpackage

/* core/zero_servo_position_hold.sv */
`timescale 1ns/1ps
`default_nettype none

module zero_servo_position_hold (
    input  wire logic                                        clk_i,
    input  wire logic                                        arst_n_i,
    input  wire logic                                        run_i,
    input  wire logic [zero_servo_pkg::NUM_CONTACT_INPUTS-1:0]  contact_in_i,
    input  wire logic [zero_servo_pkg::NUM_CONTACT_INPUTS*8-1:0] input_func_i,
    input  wire logic [zero_servo_pkg::NUM_CONTACT_OUTPUTS*8-1:0] output_func_i,
    input  wire logic [15:0]                                 speed_ref_i,
    input  wire logic [15:0]                                 zero_speed_threshold_i,
    input  wire logic [15:0]                                 min_output_frequency_i,
    input  wire logic [6:0]                                  position_hold_gain_i,
    input  wire logic [13:0]                                 hold_complete_width_i,
    input  wire logic                                        enc_a_i,
    input  wire logic                                        enc_b_i,
    output var  logic                                        hold_active_o,
    output var  logic                                        hold_complete_o,
    output var  logic [zero_servo_pkg::NUM_CONTACT_OUTPUTS-1:0] contact_out_o,
    output var  logic signed [15:0]                          hold_effort_o,
    output var  logic signed [31:0]                          position_error_o
);
    import zero_servo_pkg::*;

    // ==========================================
    // helpers
    function automatic logic [POS_W-1:0] abs_val(input logic signed [POS_W-1:0] v);
        abs_val = v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
    endfunction

    function automatic logic [15:0] clamp_u16(input logic [15:0] v, input logic [15:0] mx);
        clamp_u16 = (v > mx) ? mx : v;
    endfunction

    // ==========================================
    // settings, captured only while stopped
    logic [15:0] thr_reg,   thr_next;
    logic [6:0]  gain_reg,  gain_next;
    logic [13:0] width_reg, width_next;

    // trade-off: settings follow their inputs on every stopped cycle, so a
    // change made just before run is raised is still taken
    always_comb begin
        thr_next   = thr_reg;
        gain_next  = gain_reg;
        width_next = width_reg;
        if (!run_i) begin
            thr_next   = clamp_u16(zero_speed_threshold_i, ZERO_SPEED_MAX);
            gain_next  = (position_hold_gain_i > HOLD_GAIN_MAX) ? HOLD_GAIN_MAX
                                                                : position_hold_gain_i;
            width_next = hold_complete_width_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            thr_reg   <= ZERO_SPEED_DEFAULT;
            gain_reg  <= HOLD_GAIN_DEFAULT;
            width_reg <= HOLD_WIDTH_DEFAULT;
        end else begin
            thr_reg   <= thr_next;
            gain_reg  <= gain_next;
            width_reg <= width_next;
        end
    end

    // ==========================================
    // command decode and effective threshold
    logic        cmd;
    logic [15:0] eff_thr;

    always_comb begin
        cmd = 1'b0;
        for (int i = 0; i < NUM_CONTACT_INPUTS; i++) begin
            if (input_func_i[i*8 +: 8] == ZERO_SERVO_CMD_CODE && contact_in_i[i]) begin
                cmd = 1'b1;
            end
        end
        eff_thr = (thr_reg < min_output_frequency_i) ? min_output_frequency_i
                                                     : thr_reg;
    end

    // ==========================================
    // quadrature decode, one count per edge
    // limitation: encoder lines are taken as synchronous; a free-running
    // encoder needs a two-stage synchroniser in front of this block
    // count wraps at 32 bits; the error is taken modulo the same width,
    // so a wrap between latch and now still gives the right signed distance
    logic [1:0]       ab_reg,  ab_next;
    logic [POS_W-1:0] pos_reg, pos_next;

    always_comb begin
        ab_next  = {enc_a_i, enc_b_i};
        pos_next = pos_reg;
        // gray sequence 00-01-11-10 forward; double steps ignored as glitches
        case ({ab_reg, ab_next})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: pos_next = pos_reg + 32'h0000_0001;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: pos_next = pos_reg - 32'h0000_0001;
            default:                            pos_next = pos_reg;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ab_reg  <= 2'b00;
            pos_reg <= 32'h0000_0000;
        end else begin
            ab_reg  <= ab_next;
            pos_reg <= pos_next;
        end
    end

    // ==========================================
    // hold state machine and position loop
    zs_state_type       state_reg,    state_next;
    logic [POS_W-1:0]   ref_reg,      ref_next;
    logic signed [31:0] err_reg,      err_next;
    logic signed [15:0] effort_reg,   effort_next;
    logic               complete_reg, complete_next;
    logic [NUM_CONTACT_OUTPUTS-1:0] cout_reg, cout_next;
    logic               active_reg,   active_next;

    always_comb begin
        logic signed [POS_W-1:0] err;
        logic signed [47:0]      prod;
        logic                    in_hold;
        err           = '0;
        prod          = '0;
        in_hold       = 1'b0;
        state_next    = state_reg;
        ref_next      = ref_reg;
        case (state_reg)
            ST_IDLE: begin
                // strict compares: a reference equal to the threshold neither
                // enters nor leaves, one step of hysteresis
                if (run_i && cmd && speed_ref_i < eff_thr) begin
                    state_next = ST_HOLD;
                    ref_next   = pos_reg;
                end
            end
            ST_HOLD: begin
                // stop of output ends hold as well
                if (!run_i || !cmd || speed_ref_i > eff_thr) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        in_hold = (state_next == ST_HOLD);
        // registered copy of the state, so the status pin is a plain flop
        active_next = in_hold;
        err     = $signed(ref_next) - $signed(pos_reg);
        // restoring effort toward the held position, saturated
        // gain of zero leaves the loop open while the window flag still tracks
        prod    = 48'(err) * $signed({41'd0, gain_reg});
        if (!in_hold) begin
            effort_next = '0;
        end else if (prod > $signed(48'(EFFORT_MAX))) begin
            effort_next = $signed(EFFORT_MAX);
        end else if (prod < -$signed(48'(EFFORT_MAX))) begin
            effort_next = -$signed(EFFORT_MAX);
        end else begin
            effort_next = prod[15:0];
        end
        err_next      = in_hold ? err : '0;
        complete_next = in_hold && cmd
                        && abs_val(err) <= {18'd0, width_reg};
        for (int j = 0; j < NUM_CONTACT_OUTPUTS; j++) begin
            cout_next[j] = (output_func_i[j*8 +: 8] == ZERO_SERVO_END_CODE)
                           && complete_next;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg    <= ST_IDLE;
            ref_reg      <= 32'h0000_0000;
            err_reg      <= 32'sh0000_0000;
            effort_reg   <= 16'sh0000;
            complete_reg <= 1'b0;
            cout_reg     <= '0;
            active_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            ref_reg      <= ref_next;
            err_reg      <= err_next;
            effort_reg   <= effort_next;
            complete_reg <= complete_next;
            cout_reg     <= cout_next;
            active_reg   <= active_next;
        end
    end

    // ==========================================
    // outputs
    // every output leaves straight from a register, so a contact or drive
    // stage downstream never sees glitches from the state compare
    assign hold_active_o    = active_reg;
    assign hold_complete_o  = complete_reg;
    assign contact_out_o    = cout_reg;
    assign hold_effort_o    = effort_reg;
    assign position_error_o = err_reg;

endmodule // zero_servo_position_hold

`default_nettype wire

/* verif/quad_encoder_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// shaft encoder, one x4 edge per step pulse
module quad_encoder_model (
    input  wire logic clk_i,
    input  wire logic fwd_i,
    input  wire logic rev_i,
    output var  logic enc_a_o,
    output var  logic enc_b_o
);
    logic [1:0] ph = 2'h0;
    always @(posedge clk_i) ph <= fwd_i ? ph + 2'h1 : (rev_i ? ph - 2'h1 : ph);
    // gray order, so each step moves only one line
    assign enc_a_o = ph[1];
    assign enc_b_o = ph[1] ^ ph[0];
endmodule // quad_encoder_model
`default_nettype wire

/* verif/zero_servo_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker
module zero_servo_assertions (
    input wire logic               clk_i,
    input wire logic               arst_n_i,
    input wire logic               run_i,
    input wire logic [9:0]         contact_in_i,
    input wire logic [79:0]        input_func_i,
    input wire logic [23:0]        output_func_i,
    input wire logic [15:0]        speed_ref_i,
    input wire logic [15:0]        min_output_frequency_i,
    input wire logic [13:0]        hold_complete_width_i,
    input wire logic               hold_active_o,
    input wire logic               hold_complete_o,
    input wire logic [2:0]         contact_out_o,
    input wire logic signed [15:0] hold_effort_o,
    input wire logic signed [31:0] position_error_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    chk_entry_taken:
    assert property (!hold_active_o && run_i && contact_in_i[2] && input_func_i[23:16] == 8'h48
        && speed_ref_i < min_output_frequency_i |=> hold_active_o) else $error("no entry");
    chk_cmd_exit:
    assert property ((!run_i || contact_in_i == 10'h000) |=> !hold_active_o && !hold_complete_o)
        else $error("no exit");
    chk_complete_hold:
    assert property (hold_complete_o |-> hold_active_o) else $error("complete outside hold");
    chk_width_window:
    assert property (hold_active_o |-> hold_complete_o == ((position_error_o < 0 ?
        -position_error_o : position_error_o) <= hold_complete_width_i)) else $error("window");
    chk_idle_zero:
    assert property (!hold_active_o |-> hold_effort_o == 0 && position_error_o == 0
        && contact_out_o == 3'h0) else $error("idle outputs");
    chk_contact_route:
    assert property ($past(output_func_i[15:8]) == 8'h21 |-> contact_out_o[1] == hold_complete_o)
        else $error("route");
    chk_effort_sign:
    assert property (position_error_o < 0 && $stable(position_error_o) |-> hold_effort_o <= 0)
        else $error("effort sign");
    chk_entry_ref:
    assert property ($rose(hold_active_o) |-> position_error_o == 0) else $error("reference");
endmodule // zero_servo_assertions
`default_nettype wire

/* verif/zero_servo_position_hold_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench
module zero_servo_position_hold_tb;
    logic clk_i = 0, arst_n_i = 0, run_i = 0, fwd = 0, rev = 0, enc_a, enc_b, act, cpl;
    logic [9:0] cin = 10'h000;
    logic [15:0] spd = 16'h0000, thr = 16'h0002, minf = 16'h0008;
    logic [2:0] cout;
    logic signed [15:0] eff;
    logic signed [31:0] err;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    quad_encoder_model enc_u (.clk_i(clk_i), .fwd_i(fwd), .rev_i(rev), .enc_a_o(enc_a),
        .enc_b_o(enc_b));
    zero_servo_position_hold dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .run_i(run_i),
        .contact_in_i(cin), .input_func_i({56'h0, 8'h48, 16'h0}), .speed_ref_i(spd),
        .output_func_i({8'h0, 8'h21, 8'h0}), .zero_speed_threshold_i(thr),
        .min_output_frequency_i(minf), .position_hold_gain_i(7'h05),
        .hold_complete_width_i(14'h0004), .enc_a_i(enc_a), .enc_b_i(enc_b),
        .hold_active_o(act), .hold_complete_o(cpl), .contact_out_o(cout),
        .hold_effort_o(eff), .position_error_o(err));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic step(input logic f, input int n);
        repeat (n) begin
            @(posedge clk_i);
            fwd <= f;
            rev <= !f;
            @(posedge clk_i);
            fwd <= 1'b0;
            rev <= 1'b0;
        end
        tick(3);
    endtask
    task automatic print_verdict;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        run_i <= 1'b1;
        cin <= 10'h001;
        spd <= 16'h0006;
        tick(2); chk(act, 0);
        @(posedge clk_i);
        cin <= 10'h004;
        spd <= 16'h0009;
        tick(2); chk(act, 0);
        @(posedge clk_i);
        spd <= 16'h0006;
        tick(1); chk(act, 1);
        chk(cpl, 1);
        chk(cout, 3'h2);
        $display("test entry done");
        step(1, 5); chk(cpl, 0);
        chk(err, 32'hffff_fffb);
        chk(eff, 32'hffff_ffe7);
        step(0, 1); chk(cpl, 1);
        step(0, 4); chk(eff, 0);
        $display("test track done");
        @(posedge clk_i);
        thr <= 16'h0064;
        minf <= 16'h0000;
        spd <= 16'h0004;
        tick(2); chk(act, 0);
        @(posedge clk_i);
        spd <= 16'h0001;
        tick(1); chk(act, 1);
        @(posedge clk_i);
        cin <= 10'h000;
        tick(1); chk(cpl, 0);
        @(posedge clk_i);
        cin <= 10'h004;
        tick(1); chk(act, 1);
        @(posedge clk_i);
        run_i <= 1'b0;
        tick(1); chk(act, 0);
        $display("test exit done");
        print_verdict;
    end
endmodule // zero_servo_position_hold_tb
bind zero_servo_position_hold zero_servo_assertions chk_u (.*);
`default_nettype wire
